// File: hdl/lpms_pkg.sv
// Shared constants and types for the low-power mode sequencer
package lpms_pkg;
    // Stop-control register layout
    localparam int TAG_LSB       = 0;
    localparam int TAG_W         = 8;
    localparam int KEY_LSB       = 8;
    localparam int KEY_W         = 8;
    localparam int POL_BIT       = 16;
    localparam int HOLD_BIT      = 17;
    localparam int STOP_BIT      = 31;
    localparam logic [7:0]  STOP_KEY        = 8'h3A;
    localparam logic [31:0] STOP_CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] STOP_CTRL_MASK  = 32'h8003_FFFF;

    // Register command codes on the firmware port
    localparam logic [1:0] REG_NONE   = 2'h0;
    localparam logic [1:0] REG_STOP   = 2'h1;
    localparam logic [1:0] REG_POWER  = 2'h2;
    localparam logic [1:0] REG_CPUSYS = 2'h3;

    // Power control / cpu system control bit positions
    localparam int LOWEST_RET_BIT  = 0;
    localparam int DEEP_SLEEP_BIT  = 0;
    localparam int AFTER_ISR_BIT   = 1;

    typedef enum logic [2:0] {
        LPMS_ACTIVE,
        LPMS_SLEEP,
        LPMS_DEEP_SLEEP,
        LPMS_HIBERNATE,
        LPMS_STOP
    } lpms_mode_type;
endpackage

// File: hdl/lpms_if.sv
// Link between the sequencer and the core/firmware side
`timescale 1ns/1ps
`default_nettype none
interface lpms_if;
    logic        wait_instruction;
    logic        isr_active;
    logic        irq_pending;
    logic [1:0]  reg_sel;
    logic        reg_wr;
    logic [31:0] reg_wdata;
    logic [31:0] stop_control_rd;
    logic [31:0] power_control_rd;
    logic [2:0]  mode;
    logic        core_reset;
    logic        core_run;

    modport seq (
        input  wait_instruction, isr_active, irq_pending,
               reg_sel, reg_wr, reg_wdata,
        output stop_control_rd, power_control_rd, mode,
               core_reset, core_run
    );
    modport core (
        output wait_instruction, isr_active, irq_pending,
               reg_sel, reg_wr, reg_wdata,
        input  stop_control_rd, power_control_rd, mode,
               core_reset, core_run
    );
endinterface
`default_nettype wire

// File: hdl/lpms_seq.sv
// Device end: power-mode sequencer with retained stop-control register
//
// How it works
// - Wait with deep-sleep clear enters Sleep
// - Deep-sleep set, lowest-retention clear: Deep-Sleep
// - Both flags set enters Hibernate
// - Regulators not ready: Sleep first, then deeper
// - After-isr flag defers entry until ISR returns
// - Hibernate keeps SRAM, stops clocks, drops state
// - Hibernate exits by pin/comparator as reset
// - Reset wakeup tristates pins unless hold set
// - External reset clears whole stop-control register
// - Stop exits only by reset or wake pin
// - Eight-bit wakeup tag survives Stop wake
// - Stop request ignored unless key is 0x3A
// - Wake when pin level equals polarity bit
// - Hold bit freezes every GPIO state
// - Stop removes logic power, keeps I/O, register
// - Stop exit clears stop bit, raises power-on reset
// - Firmware writes tag, key, polarity, hold, stop
// - Firmware reads tag, restores I/O, releases hold
// - Sleep/Deep-Sleep wake on interrupt or reset
// - Firmware sets oscillator to 12 MHz first
// - Hibernate I/O toggle rate kept low
`timescale 1ns/1ps
`default_nettype none
module lpms_seq (
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    lpms_if.seq       link,
    input  wire logic external_reset_pin_i,
    input  wire logic wake_pin_i,
    input  wire logic pin_irq_i,
    input  wire logic comparator_evt_i,
    input  wire logic regulators_ready_flag_i,
    output logic      io_hold_o,
    output logic      io_tristate_o,
    output logic      sram_retain_o,
    output logic      clocks_run_o,
    output logic      logic_power_o,
    output logic      por_o
);
    typedef struct packed {
        logic [2:0]  external_reset_pin_sync;
        logic [2:0]  wake_sync;
        logic [2:0]  pirq_sync;
        logic [2:0]  cmp_sync;
        logic [2:0]  rdy_sync;
        logic        external_reset_pin_q;
        logic        wake_q;
        logic        pirq_q;
        logic        cmp_q;
        logic        rdy_q;
        logic [31:0] stop_ctrl;
        logic        lowest_ret;
        logic        deep_sel;
        logic        after_isr;
        logic        pend;
        lpms_pkg::lpms_mode_type mode;
        logic        target_deep;
        logic        core_reset;
        logic        tristate;
        logic        por;
        logic        sram_on;
        logic        clk_on;
        logic        lv_on;
    } lpms_state_type;

    lpms_state_type state_reg;
    lpms_state_type state_next;

    // Debounced view: change counts once stages two and three agree
    function automatic logic agreed(input logic [2:0] s, input logic old);
        agreed = (s[1] == s[2]) ? s[2] : old;
    endfunction

    // Hibernate and Stop both cut clocks and low-voltage supply
    function automatic logic cut_off(input lpms_pkg::lpms_mode_type md);
        cut_off = (md == lpms_pkg::LPMS_HIBERNATE)
               || (md == lpms_pkg::LPMS_STOP);
    endfunction

    always_comb begin
        state_next = state_reg;
        state_next.external_reset_pin_sync = {state_reg.external_reset_pin_sync[1:0], external_reset_pin_i};
        state_next.wake_sync = {state_reg.wake_sync[1:0], wake_pin_i};
        state_next.pirq_sync = {state_reg.pirq_sync[1:0], pin_irq_i};
        state_next.cmp_sync  = {state_reg.cmp_sync[1:0], comparator_evt_i};
        state_next.rdy_sync  =
            {state_reg.rdy_sync[1:0], regulators_ready_flag_i};
        state_next.external_reset_pin_q = agreed(state_reg.external_reset_pin_sync, state_reg.external_reset_pin_q);
        state_next.wake_q = agreed(state_reg.wake_sync, state_reg.wake_q);
        state_next.pirq_q = agreed(state_reg.pirq_sync, state_reg.pirq_q);
        state_next.cmp_q  = agreed(state_reg.cmp_sync, state_reg.cmp_q);
        state_next.rdy_q  = agreed(state_reg.rdy_sync, state_reg.rdy_q);
        state_next.core_reset = 1'b0;
        state_next.por        = 1'b0;

        // Register writes are taken only while the core runs
        if (link.reg_wr && state_reg.mode == lpms_pkg::LPMS_ACTIVE) begin
            if (link.reg_sel == lpms_pkg::REG_STOP) begin
                state_next.stop_ctrl =
                    link.reg_wdata & lpms_pkg::STOP_CTRL_MASK;
                // Key checked against the value already held
                if (state_reg.stop_ctrl[lpms_pkg::KEY_LSB +: lpms_pkg::KEY_W]
                        != lpms_pkg::STOP_KEY) begin
                    state_next.stop_ctrl[lpms_pkg::STOP_BIT] = 1'b0;
                end
            end else if (link.reg_sel == lpms_pkg::REG_POWER) begin
                state_next.lowest_ret =
                    link.reg_wdata[lpms_pkg::LOWEST_RET_BIT];
            end else if (link.reg_sel == lpms_pkg::REG_CPUSYS) begin
                state_next.deep_sel = link.reg_wdata[lpms_pkg::DEEP_SLEEP_BIT];
                state_next.after_isr = link.reg_wdata[lpms_pkg::AFTER_ISR_BIT];
            end
        end

        case (state_reg.mode)
            lpms_pkg::LPMS_ACTIVE: begin
                if (state_reg.stop_ctrl[lpms_pkg::STOP_BIT]) begin
                    state_next.mode = lpms_pkg::LPMS_STOP;
                end else if (link.wait_instruction || state_reg.pend) begin
                    // Deferred entry waits for the last handler to return
                    if (state_reg.after_isr && link.isr_active) begin
                        state_next.pend = 1'b1;
                    end else begin
                        state_next.pend = 1'b0;
                        state_next.target_deep = state_reg.deep_sel;
                        if (!state_reg.deep_sel) begin
                            state_next.mode = lpms_pkg::LPMS_SLEEP;
                        end else if (!state_reg.rdy_q) begin
                            state_next.mode = lpms_pkg::LPMS_SLEEP;
                        end else if (state_reg.lowest_ret) begin
                            state_next.mode = lpms_pkg::LPMS_HIBERNATE;
                        end else begin
                            state_next.mode = lpms_pkg::LPMS_DEEP_SLEEP;
                        end
                    end
                end
            end
            lpms_pkg::LPMS_SLEEP, lpms_pkg::LPMS_DEEP_SLEEP: begin
                if (link.irq_pending) begin
                    state_next.mode = lpms_pkg::LPMS_ACTIVE;
                    state_next.target_deep = 1'b0;
                end else if (state_reg.mode == lpms_pkg::LPMS_SLEEP
                        && state_reg.target_deep && state_reg.rdy_q) begin
                    state_next.mode = state_reg.lowest_ret
                        ? lpms_pkg::LPMS_HIBERNATE
                        : lpms_pkg::LPMS_DEEP_SLEEP;
                end
            end
            lpms_pkg::LPMS_HIBERNATE: begin
                if (state_reg.pirq_q || state_reg.cmp_q) begin
                    state_next.mode = lpms_pkg::LPMS_ACTIVE;
                    state_next.core_reset = 1'b1;
                    state_next.target_deep = 1'b0;
                    state_next.tristate =
                        !state_reg.stop_ctrl[lpms_pkg::HOLD_BIT];
                end
            end
            lpms_pkg::LPMS_STOP: begin
                if (state_reg.wake_q == state_reg.stop_ctrl[lpms_pkg::POL_BIT])
                begin
                    state_next.mode = lpms_pkg::LPMS_ACTIVE;
                    state_next.stop_ctrl[lpms_pkg::STOP_BIT] = 1'b0;
                    state_next.por = 1'b1;
                    state_next.core_reset = 1'b1;
                    state_next.tristate =
                        !state_reg.stop_ctrl[lpms_pkg::HOLD_BIT];
                end
            end
            default: state_next.mode = lpms_pkg::LPMS_ACTIVE;
        endcase

        // Pin reset wins over everything, from any mode
        if (state_reg.external_reset_pin_q) begin
            state_next.stop_ctrl   = lpms_pkg::STOP_CTRL_RESET;
            state_next.mode        = lpms_pkg::LPMS_ACTIVE;
            state_next.pend        = 1'b0;
            state_next.target_deep = 1'b0;
            state_next.lowest_ret  = 1'b0;
            state_next.deep_sel    = 1'b0;
            state_next.after_isr   = 1'b0;
            state_next.core_reset  = 1'b1;
            state_next.por         = 1'b1;
            state_next.tristate    = 1'b1;
        end else if (state_next.tristate && !state_reg.core_reset
                && link.reg_wr) begin
            // First firmware write after wakeup reconfigures the pins
            state_next.tristate = 1'b0;
        end

        // Registered so the supply switches never see decode glitches
        state_next.sram_on = (state_next.mode != lpms_pkg::LPMS_STOP);
        state_next.clk_on  = !cut_off(state_next.mode);
        state_next.lv_on   = !cut_off(state_next.mode);
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
            state_reg.stop_ctrl <= lpms_pkg::STOP_CTRL_RESET;
            state_reg.mode <= lpms_pkg::LPMS_ACTIVE;
            state_reg.sram_on <= 1'b1;
            state_reg.clk_on <= 1'b1;
            state_reg.lv_on <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    lpms_pkg::lpms_mode_type m;
    assign m = state_reg.mode;
    assign link.stop_control_rd  = state_reg.stop_ctrl;
    assign link.power_control_rd = {30'h0000_0000, state_reg.rdy_q,
                                    state_reg.lowest_ret};
    assign link.mode             = m;
    assign link.core_reset       = state_reg.core_reset;
    assign link.core_run         = (m == lpms_pkg::LPMS_ACTIVE);
    assign io_hold_o     = state_reg.stop_ctrl[lpms_pkg::HOLD_BIT];
    assign io_tristate_o = state_reg.tristate;
    assign sram_retain_o = state_reg.sram_on;
    assign clocks_run_o  = state_reg.clk_on;
    assign logic_power_o = state_reg.lv_on;
    assign por_o         = state_reg.por;
endmodule
`default_nettype wire

// File: hdl/lpms_core.sv
// Far end: core/firmware side issuing waits and register writes
`timescale 1ns/1ps
`default_nettype none
module lpms_core (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    lpms_if.core             link,
    input  wire logic        wait_req_i,
    input  wire logic        isr_active_i,
    input  wire logic        irq_i,
    input  wire logic [1:0]  reg_sel_i,
    input  wire logic        reg_wr_i,
    input  wire logic [31:0] reg_wdata_i,
    output logic [31:0]      stop_control_o,
    output logic [31:0]      power_control_o,
    output logic [2:0]       mode_o,
    output logic             core_reset_o,
    output logic             core_run_o
);
    typedef struct packed {
        logic        wait_q;
        logic        isr_q;
        logic        irq_q;
        logic [1:0]  sel_q;
        logic        wr_q;
        logic [31:0] wdata_q;
        logic [31:0] stop_q;
        logic [31:0] pwr_q;
        logic [2:0]  mode_q;
        logic        rst_q;
        logic        run_q;
    } lpms_core_state_type;

    lpms_core_state_type state_reg;
    lpms_core_state_type state_next;

    always_comb begin
        state_next = state_reg;
        // Core issues no waits or register writes while it is halted in a low-power mode
        state_next.wait_q  = wait_req_i && link.core_run;
        state_next.wr_q    = reg_wr_i && link.core_run;
        state_next.isr_q   = isr_active_i;
        state_next.irq_q   = irq_i;
        state_next.sel_q   = reg_sel_i;
        state_next.wdata_q = reg_wdata_i;
        state_next.stop_q  = link.stop_control_rd;
        state_next.pwr_q   = link.power_control_rd;
        state_next.mode_q  = link.mode;
        state_next.rst_q   = link.core_reset;
        state_next.run_q   = link.core_run;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign link.wait_instruction = state_reg.wait_q;
    assign link.isr_active       = state_reg.isr_q;
    assign link.irq_pending      = state_reg.irq_q;
    assign link.reg_sel          = state_reg.sel_q;
    assign link.reg_wr           = state_reg.wr_q;
    assign link.reg_wdata        = state_reg.wdata_q;
    assign stop_control_o  = state_reg.stop_q;
    assign power_control_o = state_reg.pwr_q;
    assign mode_o          = state_reg.mode_q;
    assign core_reset_o    = state_reg.rst_q;
    assign core_run_o      = state_reg.run_q;
endmodule
`default_nettype wire

// File: testbench/lpms_properties.sv
// Concurrent checks on the link between sequencer and core end
`timescale 1ns/1ps
`default_nettype none
module lpms_properties (
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic        wait_instruction,
    input wire logic        isr_active,
    input wire logic        irq_pending,
    input wire logic [1:0]  reg_sel,
    input wire logic        reg_wr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] stop_control_rd,
    input wire logic [31:0] power_control_rd,
    input wire logic [2:0]  mode
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    logic act;
    logic go;
    assign act = mode == lpms_pkg::LPMS_ACTIVE;
    // Clean wait request, nothing competing with it
    assign go = act && wait_instruction && !isr_active && !irq_pending;
    sequence stop_left;
        mode == lpms_pkg::LPMS_STOP ##1 mode != lpms_pkg::LPMS_STOP;
    endsequence
    sequence woke;
        ##[1:2] act;
    endsequence
    a_wait_leaves_active: assert property (go && !reg_wr |=> !act)
        else $error("wait did not leave active");
    a_unready_sleeps: assert property (go && !power_control_rd[1]
        |=> mode == lpms_pkg::LPMS_SLEEP)
        else $error("unready regulators did not give sleep");
    a_hib_flag_set: assert property (mode == lpms_pkg::LPMS_HIBERNATE
        && $past(mode) != lpms_pkg::LPMS_HIBERNATE
        |-> $past(power_control_rd[0]))
        else $error("hibernate without lowest-retention flag");
    a_deep_flag_clear: assert property (mode == lpms_pkg::LPMS_DEEP_SLEEP
        && $past(mode) != lpms_pkg::LPMS_DEEP_SLEEP
        |-> !$past(power_control_rd[0]))
        else $error("deep sleep with lowest-retention flag");
    a_key_guard: assert property (act && reg_wr
        && reg_sel == lpms_pkg::REG_STOP && reg_wdata[31]
        && stop_control_rd[15:8] != lpms_pkg::STOP_KEY
        && !stop_control_rd[31] |=> !stop_control_rd[31])
        else $error("stop bit taken without key");
    a_stop_exit_clears: assert property (stop_left
        |-> ##[0:2] !stop_control_rd[31])
        else $error("stop bit kept after exit");
    a_irq_wakes: assert property ((mode == lpms_pkg::LPMS_SLEEP
        || mode == lpms_pkg::LPMS_DEEP_SLEEP) && irq_pending |-> woke)
        else $error("interrupt did not wake");
    a_unused_zero: assert property (stop_control_rd[30:18] == 13'h0)
        else $error("unused stop-control bits set");
endmodule
`default_nettype wire

// File: testbench/test_low_power_mode_sequencer.sv
// Self-checking bench joining the sequencer and the core end
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_count++; \
    $display("BAD %s exp %h got %h", n, e, a); end end
module test_low_power_mode_sequencer;
    logic        ref_clk_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic        ext_rst   = 1'b0;
    logic        wake_pin  = 1'b0;
    logic        pin_irq   = 1'b0;
    logic        cmp_evt   = 1'b0;
    logic        reg_ready = 1'b1;
    logic        wait_req  = 1'b0;
    logic        isr_act   = 1'b0;
    logic        irq       = 1'b0;
    logic [1:0]  sel       = 2'h0;
    logic        wr_en     = 1'b0;
    logic [31:0] wdata     = 32'h0;
    logic [31:0] stop_ctl;
    logic [2:0]  mode;
    logic        io_hold;
    logic        io_tri;
    logic        sram_ret;
    logic        clk_run;
    logic        lp_pwr;
    logic        por;
    logic [31:0] pwr_ctl;
    logic        core_rst;
    logic        core_run;
    int          por_count = 0;
    int          rst_count = 0;
    int          err_count = 0;
    int          checked = 0;
    always #2.5 ref_clk_i = ~ref_clk_i;
    // Pulse counters, so a missing or doubled pulse both show
    always @(posedge ref_clk_i) begin
        if (por) por_count <= por_count + 1;
        if (core_rst) rst_count <= rst_count + 1;
    end
    lpms_if link();
    lpms_seq lpms_seq_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .link(link), .external_reset_pin_i(ext_rst), .wake_pin_i(wake_pin),
        .pin_irq_i(pin_irq), .comparator_evt_i(cmp_evt),
        .regulators_ready_flag_i(reg_ready), .io_hold_o(io_hold),
        .io_tristate_o(io_tri), .sram_retain_o(sram_ret),
        .clocks_run_o(clk_run), .logic_power_o(lp_pwr), .por_o(por));
    lpms_core lpms_core_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .link(link), .wait_req_i(wait_req), .isr_active_i(isr_act),
        .irq_i(irq), .reg_sel_i(sel), .reg_wr_i(wr_en), .reg_wdata_i(wdata),
        .stop_control_o(stop_ctl), .power_control_o(pwr_ctl), .mode_o(mode),
        .core_reset_o(core_rst), .core_run_o(core_run));
    lpms_properties lpms_properties_inst (.ref_clk_i(ref_clk_i),
        .rst_i(rst_i), .wait_instruction(link.wait_instruction),
        .isr_active(link.isr_active), .irq_pending(link.irq_pending),
        .reg_sel(link.reg_sel), .reg_wr(link.reg_wr),
        .reg_wdata(link.reg_wdata), .stop_control_rd(link.stop_control_rd),
        .power_control_rd(link.power_control_rd), .mode(link.mode));
    task automatic tick(int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    // Pins pass a synchroniser, so levels are held several cycles
    task automatic pulse(ref logic s, input int n);
        @(negedge ref_clk_i);
        s = 1'b1;
        tick(n);
        s = 1'b0;
    endtask
    task automatic wr(logic [1:0] s, logic [31:0] d);
        @(negedge ref_clk_i);
        sel = s;
        wdata = d;
        wr_en = 1'b1;
        @(negedge ref_clk_i);
        wr_en = 1'b0;
        tick(3);
    endtask
    task automatic want(lpms_pkg::lpms_mode_type m);
        for (int k = 0; k < 20 && mode !== 3'(m); k++) @(negedge ref_clk_i);
        `CHK("mode", 3'(m), mode)
    endtask
    task automatic t_sleep();
        for (int h = 0; h < 2; h++) begin
            wr(lpms_pkg::REG_POWER, 32'(h));
            wr(lpms_pkg::REG_CPUSYS, 32'h0);
            pulse(wait_req, 1);
            want(lpms_pkg::LPMS_SLEEP);
            pulse(irq, 1);
            want(lpms_pkg::LPMS_ACTIVE);
        end
    endtask
    task automatic t_defer();
        wr(lpms_pkg::REG_CPUSYS, 32'h2);
        isr_act = 1'b1;
        pulse(wait_req, 1);
        tick(6);
        `CHK("mode", 3'(lpms_pkg::LPMS_ACTIVE), mode)
        isr_act = 1'b0;
        want(lpms_pkg::LPMS_SLEEP);
        pulse(irq, 1);
        want(lpms_pkg::LPMS_ACTIVE);
    endtask
    task automatic t_deep();
        reg_ready = 1'b0;
        wr(lpms_pkg::REG_POWER, 32'h0);
        wr(lpms_pkg::REG_CPUSYS, 32'h1);
        pulse(wait_req, 1);
        want(lpms_pkg::LPMS_SLEEP);
        `CHK("ready", 1'b0, pwr_ctl[1])
        reg_ready = 1'b1;
        want(lpms_pkg::LPMS_DEEP_SLEEP);
        `CHK("ready", 1'b1, pwr_ctl[1])
        pulse(irq, 1);
        want(lpms_pkg::LPMS_ACTIVE);
    endtask
    task automatic t_hib(logic cmp);
        int r0;
        wr(lpms_pkg::REG_POWER, 32'h1);
        wr(lpms_pkg::REG_CPUSYS, 32'h1);
        pulse(wait_req, 1);
        want(lpms_pkg::LPMS_HIBERNATE);
        `CHK("clocks", 1'b0, clk_run)
        `CHK("sram", 1'b1, sram_ret)
        `CHK("power", 1'b0, lp_pwr)
        `CHK("lowret", 1'b1, pwr_ctl[0])
        `CHK("run", 1'b0, core_run)
        pulse(irq, 6);
        `CHK("mode", 3'(lpms_pkg::LPMS_HIBERNATE), mode)
        r0 = rst_count;
        if (cmp) pulse(cmp_evt, 6);
        else pulse(pin_irq, 6);
        want(lpms_pkg::LPMS_ACTIVE);
        `CHK("run", 1'b1, core_run)
        `CHK("tristate", 1'b1, io_tri)
        wr(lpms_pkg::REG_CPUSYS, 32'h0);
        `CHK("tristate", 1'b0, io_tri)
        `CHK("corereset", r0 + 1, rst_count)
    endtask
    task automatic t_stop();
        int p0;
        wr(lpms_pkg::REG_STOP, 32'h0000_00A5);
        wr(lpms_pkg::REG_STOP, 32'h8000_00A5);
        `CHK("stopctl", 32'h0000_00A5, stop_ctl)
        wr(lpms_pkg::REG_STOP, 32'h0000_3AA5);
        wr(lpms_pkg::REG_STOP, 32'h0001_3AA5);
        tick(2);
        wr(lpms_pkg::REG_STOP, 32'h0003_3AA5);
        `CHK("hold", 1'b1, io_hold)
        wr(lpms_pkg::REG_STOP, 32'h8003_3AA5);
        want(lpms_pkg::LPMS_STOP);
        `CHK("power", 1'b0, lp_pwr)
        `CHK("sram", 1'b0, sram_ret)
        pulse(irq, 6);
        `CHK("mode", 3'(lpms_pkg::LPMS_STOP), mode)
        p0 = por_count;
        wake_pin = 1'b1;
        want(lpms_pkg::LPMS_ACTIVE);
        wake_pin = 1'b0;
        tick(3);
        `CHK("stopctl", 32'h0003_3AA5, stop_ctl)
        `CHK("por", p0 + 1, por_count)
        `CHK("hold", 1'b1, io_hold)
        `CHK("tristate", 1'b0, io_tri)
        wr(lpms_pkg::REG_STOP, 32'h0000_00A5);
        `CHK("hold", 1'b0, io_hold)
    endtask
    task automatic t_pinrst();
        int p0;
        wr(lpms_pkg::REG_STOP, 32'h0003_3AA5);
        wr(lpms_pkg::REG_STOP, 32'h8003_3AA5);
        want(lpms_pkg::LPMS_STOP);
        p0 = por_count;
        pulse(ext_rst, 6);
        want(lpms_pkg::LPMS_ACTIVE);
        tick(3);
        `CHK("stopctl", 32'h0, stop_ctl)
        `CHK("hold", 1'b0, io_hold)
        `CHK("por", 1'b1, por_count > p0)
        `CHK("tristate", 1'b1, io_tri)
    endtask
    task automatic end_sim();
        if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        tick(16);
        rst_i = 1'b0;
        t_sleep();
        t_defer();
        t_deep();
        t_hib(1'b0);
        t_hib(1'b1);
        t_stop();
        t_pinrst();
        end_sim();
    end
    // Whole run is a few hundred cycles; a hang ends far later
    initial begin
        #60000;
        err_count++;
        end_sim();
    end
endmodule
`default_nettype wire
